//--- rtl/ppc_pkg.sv
package ppc_pkg;
	// Clock of the block and the count-clock derivation.
	localparam int unsigned CLK_FREQ_MHZ   = 50;
	localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_FREQ_MHZ;
	localparam int unsigned PRESCALE_DIV   = 4;
	localparam int unsigned SRC_FREQ_MHZ   = 48;
	localparam real         RESOLUTION_NS  = 83.3;
	localparam int unsigned TICK_NS        = CLK_PERIOD_NS * PRESCALE_DIV;
	localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned MAX_PERIOD_S   = 358;

	// Counter and tally widths.
	localparam int unsigned CNT_W          = 16;
	localparam int unsigned TALLY_W        = 16;
	localparam int unsigned PERIOD_W       = CNT_W + TALLY_W;
	localparam logic [15:0] CNT_MAX        = 16'hFFFF;
	localparam logic [15:0] TALLY_MAX      = 16'hFFFF;
	localparam logic [15:0] CNT_RST        = 16'h0000;
	localparam logic [15:0] TALLY_RST      = 16'h0000;
	localparam logic [31:0] PERIOD_RST     = 32'h0000_0000;

	// Register map, byte addresses.
	localparam int unsigned AXI_AW         = 8;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_STATUS     = 8'h04;
	localparam logic [7:0]  OFS_COUNT      = 8'h08;
	localparam logic [7:0]  OFS_CAPTURE    = 8'h0C;
	localparam logic [7:0]  OFS_TALLY      = 8'h10;
	localparam logic [7:0]  OFS_PERIOD     = 8'h14;
	localparam logic [7:0]  OFS_PRIO       = 8'h18;

	// Field positions.
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned CTRL_ERRCLR_BIT = 1;
	localparam int unsigned ST_CAP_BIT     = 0;
	localparam int unsigned ST_OVF_BIT     = 1;
	localparam int unsigned ST_RES_BIT     = 2;
	localparam int unsigned ST_MEAS_BIT    = 3;
	localparam int unsigned ST_ERR_BIT     = 4;
	localparam logic [3:0]  PRIO_CAPTURE_A = 4'h3;
	localparam logic [3:0]  PRIO_OVERFLOW  = 4'h4;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [3:0] {
		MS_IDLE       = 4'h1,
		MS_WAIT_FIRST = 4'h2,
		MS_MEASURE    = 4'h4,
		MS_ERROR      = 4'h8
	} ppc_meas_e;
endpackage

//--- rtl/ppc_tmr_if.sv
`timescale 1ns/10ps
interface ppc_tmr_if;
	import ppc_pkg::*;
	logic             run;
	logic             cap_evt;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] cap_val;
	logic             ovf_evt;
	modport ctl (output run, output cap_evt, input cnt, input cap_val, input ovf_evt);
	modport tmr (input run, input cap_evt, output cnt, output cap_val, output ovf_evt);
endinterface

//--- rtl/ppc_timer.sv
`timescale 1ns/10ps
module ppc_timer #(
	parameter int unsigned PRESCALE = ppc_pkg::PRESCALE_DIV
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	ppc_tmr_if.tmr    bus
);
	import ppc_pkg::*;
	localparam int unsigned    PW         = $clog2(PRESCALE + 1);
	localparam logic [PW-1:0]  PRESC_LAST = PW'(PRESCALE - 1);

	logic [PW-1:0]    presc_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cap_q;
	wire logic        tick;

	// Count clock is the block clock divided down; no sync inputs exist.
	assign tick = bus.run && (presc_q == PRESC_LAST);
	assign bus.ovf_evt = tick && (cnt_q == CNT_MAX) && !bus.cap_evt;
	assign bus.cnt = cnt_q;
	assign bus.cap_val = cap_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			presc_q <= '0;
		end else if (!bus.run || tick) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	// A capture clears the counter even on a tick, so FFFFh is captured and no overflow is seen.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= CNT_RST;
			cap_q <= CNT_RST;
		end else if (bus.cap_evt) begin
			cnt_q <= CNT_RST;
			cap_q <= cnt_q;
		end else if (tick) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_prescale_gap: assert property (tick |=> !tick [*3]) else $error("count tick too early");
	a_count_hold: assert property (
		(!tick && !bus.cap_evt) |=> $stable(cnt_q)) else $error("counter moved without tick");
	a_capture_latch: assert property (
		bus.cap_evt |=> cap_q == $past(cnt_q)) else $error("capture value wrong");
	a_capture_clear: assert property (
		bus.cap_evt |=> cnt_q == 16'h0000) else $error("counter not cleared by capture");
	a_wrap_flag: assert property (
		(tick && cnt_q == 16'hFFFF && !bus.cap_evt) |-> bus.ovf_evt ##1 cnt_q == 16'h0000)
		else $error("wrap without overflow flag");
	a_ffff_capture: assert property (
		(bus.cap_evt && cnt_q == 16'hFFFF) |-> !bus.ovf_evt ##1 cap_q == 16'hFFFF)
		else $error("FFFFh capture mishandled");
endmodule

//--- rtl/ppc_top.sv
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module ppc_top (
	input  wire logic                        clk_sys_i,
	input  wire logic                        arst_n_i,
	input  wire logic                        capture_input_pin_i,
	output wire logic                        err_signal_o,
	output wire logic                        capture_a_irq_o,
	output wire logic                        group1_irq_o,
	input  wire logic [ppc_pkg::AXI_AW-1:0]  s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output wire logic                        s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output wire logic                        s_axi_wready_o,
	output wire logic [1:0]                  s_axi_bresp_o,
	output wire logic                        s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [ppc_pkg::AXI_AW-1:0]  s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output wire logic                        s_axi_arready_o,
	output wire logic [31:0]                 s_axi_rdata_o,
	output wire logic [1:0]                  s_axi_rresp_o,
	output wire logic                        s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i
);
	import ppc_pkg::*;

	logic [1:0]          rst_sync_q;
	wire logic           rst_n;
	logic [2:0]          pin_sync_q;
	wire logic           pin_rise;
	ppc_meas_e           state_q;
	ppc_meas_e           state_d;
	wire logic           in_meas;
	wire logic           cap_evt;
	wire logic           ovf_evt;
	logic                start_q;
	logic                err_q;
	logic                cap_irq_q;
	logic                g1_irq_q;
	logic                cap_pend_q;
	logic                ovf_pend_q;
	logic                res_pend_q;
	logic [TALLY_W-1:0]  tally_q;
	logic [PERIOD_W-1:0] period_q;

	// Bus-side registers.
	logic                aw_got_q;
	logic                w_got_q;
	logic [AXI_AW-1:0]   awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [1:0]          rresp_q;
	logic [31:0]         rdata_q;

	ppc_tmr_if u_tmr_if ();

	ppc_timer #(
		.PRESCALE (PRESCALE_DIV)
	) u_timer (
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_n),
		.bus     (u_tmr_if.tmr)
	);

	// The reset is released through two flops so no flop leaves reset on a partial edge.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// The pin is asynchronous; the edge is taken only after two flops.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_q <= 3'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], capture_input_pin_i};
		end
	end
	assign pin_rise = pin_sync_q[1] && !pin_sync_q[2];

	assign in_meas = (state_q == MS_WAIT_FIRST) || (state_q == MS_MEASURE);
	assign u_tmr_if.run = in_meas;
	assign cap_evt = pin_rise && in_meas;
	assign u_tmr_if.cap_evt = cap_evt;
	assign ovf_evt = u_tmr_if.ovf_evt;

	// Write decode.
	wire logic       wr_fire;
	wire logic [5:0] wr_idx;
	wire logic       wr_ctrl;
	wire logic       wr_status;
	wire logic       wr_known;
	wire logic       err_clr;
	wire logic [4:0] st_clr;
	assign wr_fire   = aw_got_q && w_got_q && !bvalid_q;
	assign wr_idx    = awaddr_q[7:2];
	assign wr_ctrl   = wr_fire && (wr_idx == OFS_CTRL[7:2]) && wstrb_q[0];
	assign wr_status = wr_fire && (wr_idx == OFS_STATUS[7:2]) && wstrb_q[0];
	assign wr_known  = (wr_idx <= OFS_PRIO[7:2]);
	assign err_clr   = wr_ctrl && wdata_q[CTRL_ERRCLR_BIT];
	assign st_clr    = wr_status ? wdata_q[4:0] : 5'h00;

	// Measurement sequencing.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MS_IDLE: begin
				if (start_q) state_d = MS_WAIT_FIRST;
			end
			MS_WAIT_FIRST: begin
				if (!start_q) state_d = MS_IDLE;
				else if (cap_evt) state_d = MS_MEASURE;
			end
			MS_MEASURE: begin
				if (ovf_evt && tally_q == TALLY_MAX) state_d = MS_ERROR;
				else if (!start_q) state_d = MS_IDLE;
			end
			MS_ERROR: begin
				if (err_clr) state_d = MS_IDLE;
			end
			default: state_d = MS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= MS_IDLE;
			err_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			err_q   <= (state_d == MS_ERROR);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= 1'b0;
		end else if (wr_ctrl) begin
			start_q <= wdata_q[CTRL_START_BIT];
		end
	end

	// The tally saturates; the error state stops the counter rather than letting it wrap.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			tally_q <= TALLY_RST;
		end else if (cap_evt) begin
			tally_q <= TALLY_RST;
		end else if (ovf_evt && state_q == MS_MEASURE && tally_q != TALLY_MAX) begin
			tally_q <= tally_q + 1'b1;
		end
	end

	// The period is tally and capture side by side, a tick count below 2^32 ticks.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			period_q <= PERIOD_RST;
		end else if (cap_evt && state_q == MS_MEASURE) begin
			period_q <= {tally_q, u_tmr_if.cnt};
		end
	end

	// Request pulses and sticky pending flags; a new event wins over a same-cycle clear.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			cap_irq_q  <= 1'b0;
			g1_irq_q   <= 1'b0;
			cap_pend_q <= 1'b0;
			ovf_pend_q <= 1'b0;
			res_pend_q <= 1'b0;
		end else begin
			cap_irq_q  <= cap_evt;
			g1_irq_q   <= ovf_evt;
			cap_pend_q <= (cap_pend_q && !st_clr[ST_CAP_BIT]) || cap_evt;
			ovf_pend_q <= (ovf_pend_q && !st_clr[ST_OVF_BIT]) || ovf_evt;
			res_pend_q <= (res_pend_q && !st_clr[ST_RES_BIT]) || (cap_evt && state_q == MS_MEASURE);
		end
	end

	assign err_signal_o    = err_q;
	assign capture_a_irq_o = cap_irq_q;
	assign group1_irq_o    = g1_irq_q;

	// Write channel: address and data are taken in either order, response after both.
	assign s_axi_awready_o = !aw_got_q && !bvalid_q;
	assign s_axi_wready_o  = !w_got_q && !bvalid_q;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o  = bresp_q;

	// Read selection.
	wire logic [5:0]  rd_idx;
	wire logic [31:0] st_word;
	wire logic [31:0] rd_word;
	wire logic        rd_known;
	assign rd_idx   = s_axi_araddr_i[7:2];
	assign st_word  = {27'h0000000, err_q, in_meas, res_pend_q, ovf_pend_q, cap_pend_q};
	assign rd_known = (rd_idx <= OFS_PRIO[7:2]);
	assign rd_word  =
		(rd_idx == OFS_CTRL[7:2])    ? {31'h00000000, start_q} :
		(rd_idx == OFS_STATUS[7:2])  ? st_word :
		(rd_idx == OFS_COUNT[7:2])   ? {16'h0000, u_tmr_if.cnt} :
		(rd_idx == OFS_CAPTURE[7:2]) ? {16'h0000, u_tmr_if.cap_val} :
		(rd_idx == OFS_TALLY[7:2])   ? {16'h0000, tally_q} :
		(rd_idx == OFS_PERIOD[7:2])  ? period_q :
		(rd_idx == OFS_PRIO[7:2])    ? {24'h000000, PRIO_OVERFLOW, PRIO_CAPTURE_A} :
		32'h0000_0000;

	assign s_axi_arready_o = !rvalid_q;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= rd_word;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rresp_o  = rresp_q;
	assign s_axi_rdata_o  = rdata_q;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	a_capture_irq_pulse: assert property (
		cap_evt |=> capture_a_irq_o ##1 (!capture_a_irq_o || $past(cap_evt)))
		else $error("capture request missing");
	a_group1_only: assert property (
		ovf_evt |=> group1_irq_o && !capture_a_irq_o) else $error("overflow not on group line");
	a_prio_order: assert property (
		(s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] == OFS_PRIO[7:2])
		|=> s_axi_rdata_o[7:4] > s_axi_rdata_o[3:0] && s_axi_rdata_o[3:0] == 4'h3)
		else $error("priority levels wrong");
	a_tally_step: assert property (
		(ovf_evt && state_q == MS_MEASURE && tally_q != 16'hFFFF)
		|=> tally_q == $past(tally_q) + 16'h0001) else $error("tally did not step");
	a_error_stop: assert property (
		(ovf_evt && state_q == MS_MEASURE && tally_q == 16'hFFFF)
		|=> err_signal_o && !u_tmr_if.run) else $error("tally overrun not stopped");
	a_first_edge: assert property (
		(cap_evt && state_q == MS_WAIT_FIRST)
		|=> $stable(period_q) && !$rose(res_pend_q)) else $error("first edge gave a period");
	a_period_form: assert property (
		(cap_evt && state_q == MS_MEASURE)
		|=> period_q == {$past(tally_q), u_tmr_if.cap_val}) else $error("period formula broken");
	a_pend_set_wins: assert property (
		(ovf_evt && st_clr[ST_OVF_BIT]) |=> ovf_pend_q) else $error("overflow pending lost");
endmodule

//--- test/ppc_pulse_src.sv
`timescale 1ns/10ps
module ppc_pulse_src (
	input  wire logic        clk_i,
	input  wire logic        run_i,
	input  wire logic [15:0] gap_i,
	output logic             pin_o
);
	logic [15:0] cnt_q;
	initial begin
		cnt_q = 16'h0000;
		pin_o = 1'b0;
	end
	// Rising edges come every gap_i clocks; four clocks high keeps each one visible through the synchroniser.
	always @(posedge clk_i) begin
		if (!run_i) begin
			cnt_q <= 16'h0000;
			pin_o <= 1'b0;
		end else begin
			cnt_q <= (cnt_q >= gap_i - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
			pin_o <= (cnt_q < 16'h0004);
		end
	end
endmodule

//--- test/tb_pulse_period_capture.sv
`timescale 1ns/10ps
module tb_pulse_period_capture;
	import ppc_pkg::*;
	logic        clk_sys_i, arst_n_i, pin, src_run, err_o, cap_irq, ovf_irq, cap_prev;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [15:0] src_gap;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          error_cnt = 0;
	int          checks = 0;
	int          cap_n = 0;
	int          dbl_n = 0;
	int          ovf_n = 0;

	ppc_top i_dut (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .capture_input_pin_i(pin), .err_signal_o(err_o),
		.capture_a_irq_o(cap_irq), .group1_irq_o(ovf_irq), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
	);
	ppc_pulse_src i_src (.clk_i(clk_sys_i), .run_i(src_run), .gap_i(src_gap), .pin_o(pin));

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i) begin
		cap_prev <= cap_irq;
		if (cap_irq === 1'b1) cap_n <= cap_n + 1;
		if (cap_irq === 1'b1 && cap_prev === 1'b1) dbl_n <= dbl_n + 1;
		if (ovf_irq === 1'b1) ovf_n <= ovf_n + 1;
	end

	task automatic tally_and_finish();
		$display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic hang(input string what);
		error_cnt++;
		$display("Error %s expected answer seen timeout", what);
		tally_and_finish();
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Handshakes are judged at the falling edge, so the outcome never depends on process order at the rising one.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb, done;
		done = 1'b0;
		@(posedge clk_sys_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge clk_sys_i);
			ta = awvalid & (awready === 1'b1);
			tw = wvalid & (wready === 1'b1);
			tb = bready & (bvalid === 1'b1);
			r = bresp;
			@(posedge clk_sys_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			done = tb;
		end
		if (!done) hang("write response");
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr, done;
		done = 1'b0;
		@(posedge clk_sys_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge clk_sys_i);
			ta = arvalid & (arready === 1'b1);
			tr = rready & (rvalid === 1'b1);
			d = rdata;
			r = rresp;
			@(posedge clk_sys_i);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			done = tr;
		end
		if (!done) hang("read data");
	endtask

	task automatic wait_caps(input int target, input int bound);
		for (int n = 0; n < bound && cap_n < target; n++) @(posedge clk_sys_i);
		if (cap_n < target) hang("capture request");
		repeat (8) @(posedge clk_sys_i);
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(OFS_PRIO, d, r);
		chk("priority levels", d, 32'h0000_0043);
		axi_rd(OFS_COUNT, d, r);
		chk("count after reset", d, 32'h0000_0000);
		axi_wr(OFS_COUNT, 32'h0000_1234, r);
		chk("read-only write resp", {30'h0, r}, 32'h0000_0000);
		axi_rd(OFS_COUNT, d, r);
		chk("count held while stopped", d, 32'h0000_0000);
		axi_wr(OFS_CTRL, 32'h0000_0002, r);
		chk("error clear write resp", {30'h0, r}, 32'h0000_0000);
		axi_rd(OFS_CTRL, d, r);
		chk("error clear reads zero", d, 32'h0000_0000);
		axi_rd(8'h1C, d, r);
		chk("unmapped read resp", {30'h0, r}, 32'h0000_0002);
		chk("unmapped read data", d, 32'h0000_0000);
		axi_wr(8'h20, 32'h0000_0001, r);
		chk("unmapped write resp", {30'h0, r}, 32'h0000_0002);
		$display("t_reset done");
	endtask

	task automatic t_first_edge();
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(OFS_CTRL, 32'h0000_0001, r);
		@(posedge clk_sys_i);
		src_gap <= 16'd4000;
		src_run <= 1'b1;
		wait_caps(1, 300);
		axi_rd(OFS_STATUS, d, r);
		chk("no period after first edge", {31'h0, d[2]}, 32'h0000_0000);
		chk("measuring", {31'h0, d[3]}, 32'h0000_0001);
		chk("capture pending", {31'h0, d[0]}, 32'h0000_0001);
		axi_rd(OFS_COUNT, d, r);
		chk("count cleared by capture", {31'h0, d[15:0] < 16'h0008}, 32'h0000_0001);
		$display("t_first_edge done");
	endtask

	task automatic t_period();
		logic [31:0] d, p;
		logic [1:0]  r;
		wait_caps(2, 4300);
		axi_rd(OFS_STATUS, d, r);
		chk("no overflow to serve first", {31'h0, d[1]}, 32'h0000_0000);
		axi_rd(OFS_PERIOD, p, r);
		chk("period tally half", {16'h0, p[31:16]}, 32'h0000_0000);
		chk("period of 4000 clocks", {31'h0, p[15:0] >= 16'd998 && p[15:0] <= 16'd1001}, 32'h1);
		axi_rd(OFS_CAPTURE, d, r);
		chk("capture matches period", d, {16'h0, p[15:0]});
		axi_rd(OFS_TALLY, d, r);
		chk("tally cleared by capture", d, 32'h0000_0000);
		axi_rd(OFS_STATUS, d, r);
		chk("period ready", {31'h0, d[2]}, 32'h0000_0001);
		axi_wr(OFS_STATUS, 32'h0000_0007, r);
		axi_rd(OFS_STATUS, d, r);
		chk("status cleared", {29'h0, d[2:0]}, 32'h0000_0000);
		chk("capture requests", cap_n, 32'd2);
		$display("t_period done");
	endtask

	task automatic t_back_to_back();
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge clk_sys_i);
		src_gap <= 16'd400;
		wait_caps(cap_n + 3, 2000);
		axi_rd(OFS_PERIOD, d, r);
		chk("period of 400 clocks", {31'h0, d[15:0] >= 16'd98 && d[15:0] <= 16'd101}, 32'h1);
		chk("period tally short", {16'h0, d[31:16]}, 32'h0000_0000);
		chk("no overflow request", ovf_n, 32'd0);
		chk("error output", {31'h0, err_o}, 32'h0000_0000);
		chk("single-cycle capture pulses", dbl_n, 32'd0);
		$display("t_back_to_back done");
	endtask

	task automatic t_stop();
		logic [31:0] d, e;
		logic [1:0]  r;
		axi_wr(OFS_CTRL, 32'h0000_0000, r);
		@(posedge clk_sys_i);
		src_run <= 1'b0;
		axi_rd(OFS_COUNT, d, r);
		repeat (100) @(posedge clk_sys_i);
		axi_rd(OFS_COUNT, e, r);
		chk("count frozen when stopped", e, d);
		axi_rd(OFS_STATUS, d, r);
		chk("not measuring", {31'h0, d[3]}, 32'h0000_0000);
		$display("t_stop done");
	endtask

	task automatic t_mid_reset();
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(OFS_CTRL, 32'h0000_0001, r);
		repeat (40) @(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk("outputs after mid reset", {29'h0, err_o, cap_irq, ovf_irq}, 32'h0000_0000);
		axi_rd(OFS_CTRL, d, r);
		chk("start cleared by reset", d, 32'h0000_0000);
		axi_rd(OFS_COUNT, d, r);
		chk("count after mid reset", d, 32'h0000_0000);
		axi_rd(OFS_STATUS, d, r);
		chk("status after mid reset", d, 32'h0000_0000);
		$display("t_mid_reset done");
	endtask

	initial begin
		arst_n_i = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready, src_run} = 6'h00;
		src_gap = 16'd4000;
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		t_reset();
		t_first_edge();
		t_period();
		t_back_to_back();
		t_stop();
		t_mid_reset();
		tally_and_finish();
	end
endmodule
